// File: verilog/hfr_pkg.sv
package hfr_pkg;
   // APB register byte addresses
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_CMD     = 8'h04;
   localparam logic [7:0]  ADDR_WDATA   = 8'h08;
   localparam logic [7:0]  ADDR_RDATA   = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS  = 8'h10;
   localparam logic [7:0]  ADDR_IRQ_ST  = 8'h14;
   localparam logic [7:0]  ADDR_IRQ_MSK = 8'h18;
   // Control register fields
   localparam int          CTRL_SA_LSB  = 0;
   localparam int          CTRL_TR_BIT  = 5;
   localparam int          CTRL_DIR_BIT = 6;
   localparam int          CTRL_B8_BIT  = 7;
   localparam int          CTRL_ROLE    = 8;
   localparam int          CTRL_TXTEST  = 9;
   localparam int          CTRL_LOOP    = 10;
   localparam logic [15:0] CTRL_RESET   = 16'h0100;
   // Command codes written to the command register
   localparam logic [2:0]  CMD_EXEC     = 3'h1;
   localparam logic [2:0]  CMD_EXEC_RPT = 3'h2;
   localparam logic [2:0]  CMD_RST_IN   = 3'h3;
   localparam logic [2:0]  CMD_RST_OUT  = 3'h4;
   localparam logic [2:0]  CMD_RST_BOTH = 3'h5;
   localparam logic [2:0]  CMD_TRIGGER  = 3'h6;
   // Sizes
   localparam int          BLOCK_WORDS  = 32;
   localparam int          FIFO_DEPTH   = 32;
   localparam int          PTR_W        = 5;
   localparam int          RAM_AW       = 11;
   // Interrupt status bits
   localparam int          IRQ_DONE     = 0;
   localparam int          IRQ_TRIG     = 1;

   typedef struct packed {
      logic [4:0] subaddr;
      logic       tr;
      logic       dir_load;
   } hfr_xfer_t;

   typedef struct packed {
      logic start_bc;
      logic start_test;
      logic loop_ext;
   } hfr_trig_t;
endpackage

// File: verilog/hfr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_fifo (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // Control
   input  wire logic        clear_in,
   input  wire logic        rewind_in,
   input  wire logic        push_in,
   input  wire logic [15:0] push_data_in,
   input  wire logic        pop_in,
   // Status
   output logic [15:0]      head_out,
   output logic             empty_out,
   output logic             full_out
);
   import hfr_pkg::*;
   logic [15:0]      mem [FIFO_DEPTH];
   logic [PTR_W:0]   wp_r, wp_nxt, rp_r, rp_nxt;
   // Rewind restores the read pointer so a loaded block can be reused
   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (clear_in) begin
         wp_nxt = '0;
         rp_nxt = '0;
      end else if (rewind_in) begin
         rp_nxt = '0;
      end else begin
         if (push_in && !full_out) wp_nxt = wp_r + 1'b1;
         if (pop_in && !empty_out) rp_nxt = rp_r + 1'b1;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   always_ff @(posedge clk_in) begin
      if (push_in && !full_out && !clear_in) mem[wp_r[PTR_W-1:0]] <= push_data_in;
   end
   assign head_out  = mem[rp_r[PTR_W-1:0]];
   assign empty_out = (wp_r == rp_r);
   assign full_out  = (wp_r[PTR_W] != rp_r[PTR_W]) && (wp_r[PTR_W-1:0] == rp_r[PTR_W-1:0]);
endmodule
`default_nettype wire

// File: verilog/hfr_top.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Buffer reset command empties both FIFOs and drops the not-empty flag.
// - Output FIFO words come out in bus reception order.
// - In 8-bit mode output words are read upper byte first.
// - Input FIFO words are sent in the order written.
// - In 8-bit mode input words are assembled upper byte first.
// - Load execute copies input FIFO into the selected RAM block.
// - A finished load gives one completion pulse.
// - Unload execute moves a 32-word RAM block into output FIFO.
// - Not-empty flag rises when the first unloaded word lands.
// - A finished unload gives one completion pulse.
// - Repeat load copies retained input data into a new block, then pulses.
// - Repeat unload behaves as ordinary unload.
// - Trigger starts bus transaction or self-test per control bits.
// - Role bit high means remote terminal; reset sets it high.
// - Trigger with test bit low runs the protocol self-test.
// - Self-test loop path internal when bit low, external when high.
module hfr_top (
   // Clock and reset
   input  wire logic        CLOCK_IN,
   input  wire logic        RSTN_IN,
   // APB slave
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic [31:0]      PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   // Device status and triggers
   output logic             OUTPUT_BUFFER_NONEMPTY_FLAG_OUT,
   output logic             DONE_PULSE_OUT,
   output logic             TERMINAL_ROLE_SELECT_OUT,
   output hfr_pkg::hfr_trig_t TRIGGER_OUT,
   output logic             IRQ_OUT
);
   import hfr_pkg::*;

   typedef enum {S_IDLE, S_LOAD, S_UNLOAD} hfr_state_t;

   logic [15:0]       ram [2*BLOCK_WORDS*BLOCK_WORDS];
   hfr_state_t        st_r, st_nxt;
   logic [15:0]       ctrl_r, ctrl_nxt;
   logic [1:0]        ist_r, ist_nxt, imsk_r, imsk_nxt;
   logic [5:0]        cnt_r, cnt_nxt;
   hfr_xfer_t         xf_r, xf_nxt;
   logic              hi_wr_r, hi_wr_nxt, hi_rd_r, hi_rd_nxt;
   logic [7:0]        wbyte_r, wbyte_nxt;
   logic              done_r, done_nxt, flag_r;
   hfr_trig_t         trig_r, trig_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic [15:0]       ram_rd_r;
   logic              ram_we, ram_rd_v_r, ram_rd_v_nxt;
   logic [RAM_AW-1:0] ram_addr;
   logic              wr_acc, rd_acc, unmapped;
   logic              rd_first, rd_wait_r, rd_wait_nxt;
   logic              in_clr, out_clr, in_rew, in_push, in_pop, out_push, out_pop;
   logic [15:0]       in_wdata, in_head, out_head;
   logic              in_empty, in_full, out_empty, out_full;

   function automatic logic [RAM_AW-1:0] blk_addr(input hfr_xfer_t x, input logic [5:0] i);
      blk_addr = {x.tr, x.subaddr, i[4:0]};
   endfunction

   assign wr_acc   = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign rd_acc   = PSEL_IN && PENABLE_IN && !PWRITE_IN;
   assign rd_first = rd_acc && !rd_wait_r;
   assign unmapped = !(PADDR_IN inside {ADDR_CTRL, ADDR_CMD, ADDR_WDATA, ADDR_RDATA,
                                        ADDR_STATUS, ADDR_IRQ_ST, ADDR_IRQ_MSK});

   hfr_fifo u_in (
      .clk_in       (CLOCK_IN),
      .rstn_in      (RSTN_IN),
      .clear_in     (in_clr),
      .rewind_in    (in_rew),
      .push_in      (in_push),
      .push_data_in (in_wdata),
      .pop_in       (in_pop),
      .head_out     (in_head),
      .empty_out    (in_empty),
      .full_out     (in_full)
   );
   hfr_fifo u_out (
      .clk_in       (CLOCK_IN),
      .rstn_in      (RSTN_IN),
      .clear_in     (out_clr),
      .rewind_in    (1'b0),
      .push_in      (out_push),
      .push_data_in (ram_rd_r),
      .pop_in       (out_pop),
      .head_out     (out_head),
      .empty_out    (out_empty),
      .full_out     (out_full)
   );

   // Command, host byte assembly and transfer sequencing
   always_comb begin
      logic [2:0] cmd;
      cmd        = PWDATA_IN[2:0];
      st_nxt     = st_r;
      ctrl_nxt   = ctrl_r;
      imsk_nxt   = imsk_r;
      cnt_nxt    = cnt_r;
      xf_nxt     = xf_r;
      hi_wr_nxt  = hi_wr_r;
      hi_rd_nxt  = hi_rd_r;
      wbyte_nxt  = wbyte_r;
      done_nxt   = 1'b0;
      trig_nxt   = '0;
      in_clr     = 1'b0;
      out_clr    = 1'b0;
      in_rew     = 1'b0;
      in_push    = 1'b0;
      in_wdata   = PWDATA_IN[15:0];
      in_pop     = 1'b0;
      out_push   = 1'b0;
      out_pop    = 1'b0;
      ram_we     = 1'b0;
      ram_addr   = blk_addr(xf_r, cnt_r);
      ram_rd_v_nxt = 1'b0;
      rdata_nxt  = rdata_r;
      rd_wait_nxt = rd_first;
      if (wr_acc && PADDR_IN == ADDR_CTRL) ctrl_nxt = PWDATA_IN[15:0];
      if (wr_acc && PADDR_IN == ADDR_IRQ_MSK) imsk_nxt = PWDATA_IN[1:0];
      if (wr_acc && PADDR_IN == ADDR_WDATA) begin
         if (!ctrl_r[CTRL_B8_BIT]) begin
            in_push = 1'b1;
         end else if (!hi_wr_r) begin
            wbyte_nxt = PWDATA_IN[7:0];
            hi_wr_nxt = 1'b1;
         end else begin
            in_wdata  = {wbyte_r, PWDATA_IN[7:0]};
            in_push   = 1'b1;
            hi_wr_nxt = 1'b0;
         end
      end
      if (rd_first && PADDR_IN == ADDR_RDATA) begin
         if (!ctrl_r[CTRL_B8_BIT]) begin
            rdata_nxt = {16'h0000, out_head};
            out_pop   = 1'b1;
         end else if (!hi_rd_r) begin
            rdata_nxt = {24'h000000, out_head[15:8]};
            hi_rd_nxt = !out_empty;
         end else begin
            rdata_nxt = {24'h000000, out_head[7:0]};
            out_pop   = 1'b1;
            hi_rd_nxt = 1'b0;
         end
      end else if (rd_first) begin
         case (PADDR_IN)
            ADDR_CTRL:    rdata_nxt = {16'h0000, ctrl_r};
            ADDR_STATUS:  rdata_nxt = {27'h0000000, st_r != S_IDLE, in_full, in_empty,
                                       out_full, flag_r};
            ADDR_IRQ_ST:  rdata_nxt = {30'h00000000, ist_r};
            ADDR_IRQ_MSK: rdata_nxt = {30'h00000000, imsk_r};
            default:      rdata_nxt = '0;
         endcase
      end
      if (wr_acc && PADDR_IN == ADDR_CMD) begin
         case (cmd)
            CMD_RST_IN: begin
               in_clr    = 1'b1;
               hi_wr_nxt = 1'b0;
            end
            CMD_RST_OUT: begin
               out_clr   = 1'b1;
               hi_rd_nxt = 1'b0;
            end
            CMD_RST_BOTH: begin
               in_clr    = 1'b1;
               out_clr   = 1'b1;
               hi_wr_nxt = 1'b0;
               hi_rd_nxt = 1'b0;
            end
            CMD_TRIGGER: begin
               trig_nxt.start_bc   = ctrl_r[CTRL_TXTEST];
               trig_nxt.start_test = !ctrl_r[CTRL_TXTEST];
               trig_nxt.loop_ext   = !ctrl_r[CTRL_TXTEST] && ctrl_r[CTRL_LOOP];
            end
            CMD_EXEC, CMD_EXEC_RPT: begin
               if (st_r == S_IDLE) begin
                  xf_nxt.subaddr  = ctrl_r[CTRL_SA_LSB +: 5];
                  xf_nxt.tr       = ctrl_r[CTRL_TR_BIT];
                  xf_nxt.dir_load = ctrl_r[CTRL_DIR_BIT];
                  cnt_nxt         = '0;
                  if (ctrl_r[CTRL_DIR_BIT]) begin
                     st_nxt = S_LOAD;
                     in_rew = (cmd == CMD_EXEC_RPT);
                  end else begin
                     st_nxt = S_UNLOAD;
                  end
               end
            end
            default: ;
         endcase
      end
      case (st_r)
         S_LOAD: begin
            // Popped words stay in memory, so a repeat rewinds and copies them again
            if (in_empty || cnt_r == 6'(BLOCK_WORDS)) begin
               st_nxt   = S_IDLE;
               done_nxt = 1'b1;
            end else begin
               ram_we   = 1'b1;
               in_pop   = 1'b1;
               cnt_nxt  = cnt_r + 6'h01;
            end
         end
         S_UNLOAD: begin
            ram_rd_v_nxt = (cnt_r < 6'(BLOCK_WORDS)) && !out_full;
            if (ram_rd_v_r) out_push = 1'b1;
            if (cnt_r == 6'(BLOCK_WORDS)) begin
               if (!ram_rd_v_r) begin
                  st_nxt   = S_IDLE;
                  done_nxt = 1'b1;
               end
            end else if (!out_full) begin
               cnt_nxt = cnt_r + 6'h01;
            end
         end
         default: ;
      endcase
      if (in_clr || out_clr) begin
         if (st_r != S_IDLE) st_nxt = S_IDLE;
      end
   end

   // Block RAM: one word may be written and one word is read every cycle
   always_ff @(posedge CLOCK_IN) begin
      if (ram_we) ram[ram_addr] <= in_head;
      ram_rd_r <= ram[ram_addr];
   end

   always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         st_r       <= S_IDLE;
         ctrl_r     <= CTRL_RESET;
         imsk_r     <= '0;
         ist_r      <= '0;
         cnt_r      <= '0;
         xf_r       <= '0;
         hi_wr_r    <= 1'b0;
         hi_rd_r    <= 1'b0;
         wbyte_r    <= '0;
         done_r     <= 1'b0;
         trig_r     <= '0;
         rdata_r    <= '0;
         ram_rd_v_r <= 1'b0;
         rd_wait_r  <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         ctrl_r     <= ctrl_nxt;
         imsk_r     <= imsk_nxt;
         ist_r      <= ist_nxt;
         cnt_r      <= cnt_nxt;
         xf_r       <= xf_nxt;
         hi_wr_r    <= hi_wr_nxt;
         hi_rd_r    <= hi_rd_nxt;
         wbyte_r    <= wbyte_nxt;
         done_r     <= done_nxt;
         trig_r     <= trig_nxt;
         rdata_r    <= rdata_nxt;
         ram_rd_v_r <= ram_rd_v_nxt;
         rd_wait_r  <= rd_wait_nxt;
      end
   end

   // Sticky interrupt status: hardware set wins over write-one-to-clear
   always_comb begin
      ist_nxt = ist_r;
      if (wr_acc && PADDR_IN == ADDR_IRQ_ST) ist_nxt = ist_r & ~PWDATA_IN[1:0];
      if (done_r) ist_nxt[IRQ_DONE] = 1'b1;
      if (trig_r.start_bc || trig_r.start_test) ist_nxt[IRQ_TRIG] = 1'b1;
   end

   assign flag_r                          = !out_empty;
   assign OUTPUT_BUFFER_NONEMPTY_FLAG_OUT = flag_r;
   assign DONE_PULSE_OUT                  = done_r;
   assign TERMINAL_ROLE_SELECT_OUT        = ctrl_r[CTRL_ROLE];
   assign TRIGGER_OUT                     = trig_r;
   assign IRQ_OUT                         = |(ist_r & imsk_r);
   // Read data is registered, so reads take one wait state; writes take none
   assign PRDATA_OUT  = rdata_r;
   assign PREADY_OUT  = !rd_first;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && unmapped;


   // Assertions
   property p_done_single;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      DONE_PULSE_OUT |=> !DONE_PULSE_OUT;
   endproperty
   a_done_single: assert property (p_done_single) else $error("done pulse longer than one cycle");

   property p_rst_both_empty;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      wr_acc && PADDR_IN == ADDR_CMD && PWDATA_IN[2:0] == CMD_RST_BOTH |=> in_empty && !flag_r;
   endproperty
   a_rst_both_empty: assert property (p_rst_both_empty) else $error("buffer reset left data");

   property p_flag_on_push;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      out_push && !out_full && !out_clr |=> OUTPUT_BUFFER_NONEMPTY_FLAG_OUT;
   endproperty
   a_flag_on_push: assert property (p_flag_on_push) else $error("flag low after first word");

   property p_unload_whole;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      st_r == S_UNLOAD && st_nxt == S_IDLE && !in_clr && !out_clr |-> cnt_r == 6'(BLOCK_WORDS);
   endproperty
   a_unload_whole: assert property (p_unload_whole) else $error("unload ended short of a block");

   property p_done_irq;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      DONE_PULSE_OUT |=> ist_r[IRQ_DONE];
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("done did not set status");

   property p_trig_pulse;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      TRIGGER_OUT != 3'h0 |=> TRIGGER_OUT == 3'h0;
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");

   property p_trig_kind;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      TRIGGER_OUT.start_bc |-> !TRIGGER_OUT.start_test && !TRIGGER_OUT.loop_ext;
   endproperty
   a_trig_kind: assert property (p_trig_kind) else $error("transaction and test both started");

   property p_read_wait;
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      rd_first |=> PREADY_OUT;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state longer than one cycle");

   // Main scenarios
   c_load_done: cover property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
      st_r == S_LOAD ##1 DONE_PULSE_OUT);
   c_unload_done: cover property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
      st_r == S_UNLOAD ##1 DONE_PULSE_OUT);
   c_repeat_load: cover property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
      in_rew ##1 st_r == S_LOAD);
   c_byte_read: cover property (@(posedge CLOCK_IN) disable iff (!RSTN_IN)
      rd_first && hi_rd_r);
endmodule
`default_nettype wire

// File: tb/hfr_host.sv
`timescale 1ns/1ps
`default_nettype none
module hfr_host (
   // Clock
   input  wire logic        clk_in,
   // APB master side
   output logic             psel_out,
   output logic             penable_out,
   output logic             pwrite_out,
   output logic [7:0]       paddr_out,
   output logic [31:0]      pwdata_out,
   input  wire logic [31:0] prdata_in,
   input  wire logic        pready_in,
   input  wire logic        pslverr_in
);
   initial begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0;
   end
   // One APB transfer on rising edges; returns mid-cycle so outputs have settled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      // Only the bench watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk_in);
      end while (pready_in !== 1'b1);
      // Data and error are taken at the edge that sees ready high
      q = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Released lines show garbage, not the old value
      paddr_out <= ~a;
      pwdata_out <= ~d;
      @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// File: tb/tb_hfr_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hfr_top;
   import hfr_pkg::*;
   logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic        flag, done, role, irq, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   hfr_trig_t   trig, trig_last;
   int          num_errors, tests_run, done_cnt, trig_cnt, i, b;
   logic [15:0] wv [3] = '{16'hA5C3, 16'h0001, 16'hFFFE};
   logic [31:0] tc [3] = '{32'h200, 32'h000, 32'h400};
   logic [2:0]  te [3] = '{3'h4, 3'h2, 3'h3};

   hfr_top DUT (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OUTPUT_BUFFER_NONEMPTY_FLAG_OUT(flag),
      .DONE_PULSE_OUT(done), .TERMINAL_ROLE_SELECT_OUT(role), .TRIGGER_OUT(trig), .IRQ_OUT(irq));
   hfr_host HOST (.clk_in(clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
      .pslverr_in(pslverr));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Counting pulse cycles catches both a missing and a stretched pulse
   always @(posedge clk) begin
      if (done === 1'b1) done_cnt++;
      if (trig !== 3'h0) begin
         trig_cnt++;
         trig_last = trig;
      end
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        y;
      HOST.xfer(1'b1, a, d, x, y);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic y;
      HOST.xfer(1'b0, a, 32'h0, d, y);
   endtask
   // Base is taken before the command, as a short load may finish inside wr
   task automatic exec(input logic [2:0] c);
      int k;
      k = 0;
      b = done_cnt;
      wr(ADDR_CMD, {29'h0, c});
      while (done_cnt < b + 1 && k < 300) begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      #1;
      chk("done_count", b + 1, done_cnt);
   endtask
   task automatic unload(input logic [31:0] ctrl, input logic [2:0] c);
      wr(ADDR_CTRL, ctrl);
      exec(c);
      chk("flag_unload", 1, flag);
      for (i = 0; i < 32; i++) begin
         if (i == 31) chk("flag_last", 1, flag);
         rd(ADDR_RDATA, q);
         if (i < 3) chk("unload_word", {16'h0, wv[i]}, q);
      end
      chk("flag_drained", 0, flag);
   endtask
   task automatic final_report;
      $display("Checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      final_report;
   end

   initial begin
      rstn = 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk("flag_reset", 0, flag);
      chk("role_reset", 1, role);
      chk("irq_reset", 0, irq);
      wr(ADDR_CTRL, 32'h143);
      for (i = 0; i < 3; i++) wr(ADDR_WDATA, {16'h0, wv[i]});
      exec(CMD_EXEC);
      unload(32'h103, CMD_EXEC);
      wr(ADDR_CTRL, 32'h147);
      exec(CMD_EXEC_RPT);
      unload(32'h107, CMD_EXEC_RPT);
      // Byte mode: one word of two bytes into a fresh block
      wr(ADDR_CMD, {29'h0, CMD_RST_IN});
      wr(ADDR_CTRL, 32'h1C9);
      wr(ADDR_WDATA, 32'h12);
      wr(ADDR_WDATA, 32'h34);
      exec(CMD_EXEC);
      wr(ADDR_CTRL, 32'h189);
      exec(CMD_EXEC);
      rd(ADDR_RDATA, q);
      chk("byte_high", 32'h12, {24'h0, q[7:0]});
      rd(ADDR_RDATA, q);
      chk("byte_low", 32'h34, {24'h0, q[7:0]});
      chk("flag_partial", 1, flag);
      wr(ADDR_WDATA, 32'h56);
      wr(ADDR_WDATA, 32'h78);
      rd(ADDR_STATUS, q);
      chk("status_both_used", 32'h1, {29'h0, q[2:0]});
      wr(ADDR_CMD, {29'h0, CMD_RST_BOTH});
      chk("flag_reset_cmd", 0, flag);
      rd(ADDR_STATUS, q);
      chk("status_empty", 32'h4, {29'h0, q[2:0]});
      exec(CMD_EXEC);
      chk("flag_refill", 1, flag);
      wr(ADDR_CMD, {29'h0, CMD_RST_OUT});
      chk("flag_rst_out", 0, flag);
      for (i = 0; i < 3; i++) begin
         wr(ADDR_CTRL, tc[i]);
         b = trig_cnt;
         wr(ADDR_CMD, {29'h0, CMD_TRIGGER});
         repeat (3) @(posedge clk);
         #1;
         chk("trigger_count", b + 1, trig_cnt);
         chk("trigger_kind", {29'h0, te[i]}, {29'h0, trig_last});
      end
      chk("role_bc", 0, role);
      rd(ADDR_IRQ_ST, q);
      chk("irq_status", 3, q);
      rd(ADDR_IRQ_MSK, q);
      chk("irq_mask", 0, q);
      chk("irq_masked", 0, irq);
      wr(ADDR_IRQ_MSK, 32'h1);
      chk("irq_unmasked", 1, irq);
      wr(ADDR_IRQ_ST, 32'h3);
      chk("irq_cleared", 0, irq);
      rd(ADDR_IRQ_ST, q);
      chk("irq_status_clr", 0, q);
      HOST.xfer(1'b0, 8'hFC, 32'h0, q, e);
      chk("unmapped_err", 1, {31'h0, e});
      final_report;
   end
endmodule
`default_nettype wire
